/* File: include/dims_defines.svh */
// timing, field and encoding constants for the dram init and mode set link
`ifndef DIMS_DEFINES_SVH
`define DIMS_DEFINES_SVH

`define DIMS_CLK_PERIOD_PS     5000
`define DIMS_STABLE_TIME_US    200
`define DIMS_STABLE_CYCLES     ((`DIMS_STABLE_TIME_US * 1000000) / `DIMS_CLK_PERIOD_PS)
`define DIMS_DUMMY_MODE_SETS   2
`define DIMS_INIT_NOPS         1024
`define DIMS_BANKS             8
`define DIMS_DLL_LOCK_CYCLES   1024
`define DIMS_MODE_RECOVERY     6
`define DIMS_ADDR_W            19

`define DIMS_F_CONFIG_LO       0
`define DIMS_F_CONFIG_HI       2
`define DIMS_F_BURST_LO        3
`define DIMS_F_BURST_HI        4
`define DIMS_F_AMUX            5
`define DIMS_F_DLL             7
`define DIMS_F_IMP             8
`define DIMS_F_ODT             9
`define DIMS_F_ZERO_LO         10
`define DIMS_F_ZERO_HI_NMUX    17
`define DIMS_F_ZERO_HI_MUX     18
`define DIMS_MODE_W            18

`define DIMS_CMD_NOP           3'h0
`define DIMS_CMD_MODE_SET      3'h1
`define DIMS_CMD_REFRESH       3'h2
`define DIMS_CMD_READ          3'h3
`define DIMS_CMD_WRITE         3'h4

`define DIMS_RESET_MODE        18'h00000
`define DIMS_RESERVED_BURST    2'h3

`endif

/* File: include/dims_pkg.sv */
// types used by the memory end of the dram init and mode set link
package dims_pkg;
  typedef logic [2:0] dims_cmd_t;
  typedef struct packed {
    logic [3:0] row_cycle;
    logic [3:0] read_lat;
    logic [3:0] write_lat;
    logic       valid;
  } dims_lat_t;
endpackage

/* File: include/dims_if.sv */
// command pins between memory controller and memory
`timescale 1ns/1ps
`include "dims_defines.svh"
interface dims_if;
  logic [2:0]                 cmd;
  logic [`DIMS_ADDR_W-1:0]    addr;
  logic [2:0]                 bank;
  modport ctrl (output cmd, output addr, output bank);
  modport mem  (input cmd, input addr, input bank);
endinterface

/* File: verilog/dims_lat_decode.sv */
// latency configuration decoder of the mode register
`timescale 1ns/1ps
`include "dims_defines.svh"
module dims_lat_decode
  import dims_pkg::*;
(
  input  wire logic [2:0] config_code,
  input  wire logic       mux_mode,
  output dims_lat_t       lat
);
  always_comb begin
    lat = '{row_cycle: 4'h0, read_lat: 4'h0, write_lat: 4'h0, valid: 1'b1};
    unique case (config_code)
      3'h0, 3'h1: lat.row_cycle = 4'h4;
      3'h2:       lat.row_cycle = 4'h6;
      3'h3:       lat.row_cycle = 4'h8;
      3'h4:       lat.row_cycle = 4'h3;
      3'h5:       lat.row_cycle = 4'h5;
      default:    lat.valid = 1'b0;
    endcase
    if (lat.valid) begin
      // read equals row cycle, write one more; mux mode adds one
      lat.read_lat  = lat.row_cycle + {3'h0, mux_mode};
      lat.write_lat = lat.read_lat + 4'h1;
    end
  end
endmodule

/* File: verilog/dims_mem.sv */
// memory end: captures mode sets and decodes operating mode
`timescale 1ns/1ps
`include "dims_defines.svh"
module dims_mem
  import dims_pkg::*;
(
  input  wire logic                    clk,
  input  wire logic                    nrst,
  dims_if.mem                          pins,
  output logic                         on_die_term,
  output logic                         impedance_source_select,
  output logic                         dll_enable,
  output logic                         address_mux_select,
  output logic [1:0]                   burst_length_field,
  output logic [3:0]                   burst_beats,
  output logic [3:0]                   row_cycle_cycles,
  output logic [3:0]                   read_latency_cycles,
  output logic [3:0]                   write_latency_cycles,
  output logic                         mode_illegal
);
  typedef struct packed {
    logic [`DIMS_MODE_W-1:0] mode;
  } dims_mem_st_t;

  dims_mem_st_t st_q;
  dims_mem_st_t st_d;
  dims_lat_t    lat;
  logic [2:0]   cfg;

  always_comb begin
    st_d = st_q;
    if (pins.cmd == `DIMS_CMD_MODE_SET) begin
      st_d.mode = pins.addr[`DIMS_MODE_W-1:0];
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      st_q.mode <= `DIMS_RESET_MODE; // non-multiplexed default
    end else begin
      st_q <= st_d;
    end
  end

  assign cfg = st_q.mode[`DIMS_F_CONFIG_HI:`DIMS_F_CONFIG_LO];

  dims_lat_decode u_lat (
    .config_code (cfg),
    .mux_mode    (st_q.mode[`DIMS_F_AMUX]),
    .lat         (lat)
  );

  // field decode by bit position
  assign on_die_term             = st_q.mode[`DIMS_F_ODT];
  assign impedance_source_select = st_q.mode[`DIMS_F_IMP];
  assign dll_enable              = st_q.mode[`DIMS_F_DLL];
  assign address_mux_select      = st_q.mode[`DIMS_F_AMUX];
  assign burst_length_field = st_q.mode[`DIMS_F_BURST_HI:`DIMS_F_BURST_LO];
  assign row_cycle_cycles        = lat.row_cycle;
  assign read_latency_cycles     = lat.read_lat;
  assign write_latency_cycles    = lat.write_lat;

  always_comb begin
    burst_beats = 4'h0;
    unique case (burst_length_field)
      2'h0:    burst_beats = 4'h2;
      2'h1:    burst_beats = 4'h4;
      2'h2:    burst_beats = 4'h8;
      default: burst_beats = 4'h0;
    endcase
  end

  // eight beats need the longer configurations
  assign mode_illegal = !lat.valid
                     || (burst_length_field == `DIMS_RESERVED_BURST)
                     || (burst_length_field == 2'h2
                         && (cfg == 3'h0 || cfg == 3'h1 || cfg == 3'h4));
endmodule

/* File: verilog/dims_ctrl.sv */
// controller end: power-up sequence and mode set issue
`timescale 1ns/1ps
`include "dims_defines.svh"
module dims_ctrl
  import dims_pkg::*;
#(
  parameter int STABLE_CYCLES   = `DIMS_STABLE_CYCLES,
  parameter int RECOVERY_CYCLES = `DIMS_MODE_RECOVERY
)(
  input  wire logic                 clk,
  input  wire logic                 nrst,
  dims_if.ctrl                      pins,
  input  wire logic [`DIMS_MODE_W-1:0] mode_value,
  input  wire logic                 mode_req,
  input  wire logic                 dll_relock_req,
  input  wire logic                 banks_idle,
  output logic                      ready,
  output logic                      read_allowed,
  output logic                      busy
);
  typedef enum logic [2:0] {
    S_STABLE  = 3'b000,
    S_DUMMY   = 3'b001,
    S_VALID   = 3'b010,
    S_RECOVER = 3'b011,
    S_REFNOP  = 3'b100,
    S_READY   = 3'b101
  } dims_state_t;

  typedef struct packed {
    dims_state_t              state;
    logic [31:0]              cnt;
    logic [1:0]               dummies;
    logic [3:0]               banks_done;
    logic [10:0]              nops;
    logic [10:0]              lock;
    logic [`DIMS_MODE_W-1:0]  next_mode;
    logic                     second_set;
    logic [2:0]               cmd;
    logic [`DIMS_ADDR_W-1:0]  addr;
    logic [2:0]               bank;
  } dims_ctrl_st_t;

  dims_ctrl_st_t st_q;
  dims_ctrl_st_t st_d;

  // clears A10 upward and replaces reserved codes with safe ones
  function automatic logic [`DIMS_ADDR_W-1:0] mode_addr(
    input logic [`DIMS_MODE_W-1:0] m);
    logic [`DIMS_ADDR_W-1:0] a;
    a = '0;
    a[`DIMS_F_ODT:0] = m[`DIMS_F_ODT:0];
    a[6] = 1'b0;
    if (a[`DIMS_F_CONFIG_HI:`DIMS_F_CONFIG_LO] > 3'h5) begin
      a[`DIMS_F_CONFIG_HI:`DIMS_F_CONFIG_LO] = 3'h3;
    end
    if (a[`DIMS_F_BURST_HI:`DIMS_F_BURST_LO] == `DIMS_RESERVED_BURST) begin
      a[`DIMS_F_BURST_HI:`DIMS_F_BURST_LO] = 2'h1;
    end
    return a;
  endfunction

  always_comb begin
    st_d      = st_q;
    st_d.cmd  = `DIMS_CMD_NOP;
    st_d.addr = '0;
    st_d.bank = 3'h0;
    if (st_q.lock != 11'h0) begin
      st_d.lock = st_q.lock - 11'h1;
    end
    unique case (st_q.state)
      S_STABLE: begin
        // mode is taken late so the user may settle it during the wait
        st_d.cnt        = st_q.cnt + 32'h1;
        st_d.next_mode  = mode_value;
        st_d.second_set = mode_value[`DIMS_F_AMUX];
        if (st_q.cnt >= 32'(STABLE_CYCLES - 1)) begin
          st_d.state   = S_DUMMY;
          st_d.dummies = 2'h0;
        end
      end
      S_DUMMY: begin
        st_d.cmd     = `DIMS_CMD_MODE_SET; // address low
        st_d.dummies = st_q.dummies + 2'h1;
        if (st_q.dummies == 2'(`DIMS_DUMMY_MODE_SETS - 1)) begin
          st_d.state = S_VALID;
        end
      end
      S_VALID: begin
        st_d.cmd   = `DIMS_CMD_MODE_SET;
        st_d.addr  = mode_addr(st_q.next_mode);
        st_d.state = S_RECOVER;
        st_d.cnt   = 32'h0;
        if (st_q.next_mode[`DIMS_F_DLL]) begin
          st_d.lock = 11'(`DIMS_DLL_LOCK_CYCLES);
        end
      end
      S_RECOVER: begin
        st_d.cnt = st_q.cnt + 32'h1;
        if (st_q.cnt >= 32'(RECOVERY_CYCLES - 1)) begin
          st_d.cnt = 32'h0;
          if (st_q.second_set) begin
            // dll reset pair or mux entry: second set after recovery
            st_d.second_set = 1'b0;
            st_d.state      = S_VALID;
            st_d.next_mode  = mode_value;
          end else if (st_q.banks_done == 4'(`DIMS_BANKS)
                       && st_q.nops == 11'(`DIMS_INIT_NOPS)) begin
            st_d.state = S_READY;
          end else begin
            st_d.state = S_REFNOP;
          end
        end
      end
      S_REFNOP: begin
        // one refresh per bank every 16 cycles, nops between
        st_d.cnt = st_q.cnt + 32'h1;
        if (st_q.banks_done != 4'(`DIMS_BANKS)
            && st_q.cnt[3:0] == 4'h0) begin
          st_d.cmd        = `DIMS_CMD_REFRESH;
          st_d.bank       = st_q.banks_done[2:0];
          st_d.banks_done = st_q.banks_done + 4'h1;
        end else if (st_q.nops != 11'(`DIMS_INIT_NOPS)) begin
          st_d.nops = st_q.nops + 11'h1;
        end
        // last bank refreshed at least row cycle before ready
        if (st_q.banks_done == 4'(`DIMS_BANKS)
            && st_q.nops == 11'(`DIMS_INIT_NOPS)
            && st_q.cnt[3:0] >= 4'h8) begin
          st_d.state = S_READY;
        end
      end
      S_READY: begin
        if ((mode_req || dll_relock_req) && banks_idle) begin
          st_d.next_mode  = mode_value;
          st_d.state      = S_VALID;
          st_d.second_set = mode_value[`DIMS_F_AMUX];
          if (dll_relock_req) begin
            st_d.next_mode[`DIMS_F_DLL] = 1'b0;
            st_d.second_set             = 1'b1;
          end
        end
      end
      default: st_d.state = S_STABLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      st_q <= '{state: S_STABLE, cnt: 32'h0, dummies: 2'h0,
                banks_done: 4'h0, nops: 11'h0, lock: 11'h0,
                next_mode: `DIMS_RESET_MODE,
                second_set: 1'b0, cmd: `DIMS_CMD_NOP,
                addr: '0, bank: 3'h0};
    end else begin
      st_q <= st_d;
    end
  end

  assign pins.cmd     = st_q.cmd;
  assign pins.addr    = st_q.addr;
  assign pins.bank    = st_q.bank;
  assign ready        = (st_q.state == S_READY);
  assign read_allowed = ready && (st_q.lock == 11'h0);
  assign busy         = !ready;
endmodule

/* File: tb/dims_checker.sv */
// concurrent checks on the command pins of the link
`timescale 1ns/1ps
module dims_checker #(
  parameter int STABLE_CYCLES   = 40000,
  parameter int RECOVERY_CYCLES = 6
)(
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic [2:0]  cmd,
  input  wire logic [18:0] addr,
  input  wire logic [2:0]  bank
);
  logic [15:0] cyc_q;
  logic [7:0]  gap_q;
  logic [3:0]  ref_q;
  // gap saturates so the first dummy set never fails the recovery check
  always_ff @(posedge clk) begin
    if (!nrst) begin
      cyc_q <= 16'h0000;
      gap_q <= 8'hFF;
      ref_q <= 4'h0;
    end else begin
      cyc_q <= (cyc_q == 16'hFFFF) ? cyc_q : cyc_q + 16'h0001;
      gap_q <= (cmd == 3'h1) ? 8'h01 :
               ((gap_q == 8'hFF) ? gap_q : gap_q + 8'h01);
      ref_q <= (cmd == 3'h2) ? ref_q + 4'h1 : ref_q;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  property p_reset_nop;
    disable iff (1'b0) !nrst |=> cmd == 3'h0;
  endproperty
  a_reset_nop: assert property (p_reset_nop)
    else $error("no nop after reset");
  property p_hold_nop; cyc_q < STABLE_CYCLES |-> cmd == 3'h0; endproperty
  a_hold_nop: assert property (p_hold_nop)
    else $error("command during stable wait");
  property p_stable; cmd == 3'h1 |-> cyc_q >= STABLE_CYCLES; endproperty
  a_stable: assert property (p_stable)
    else $error("mode set too early");
  property p_triple;
    (cmd == 3'h1 && gap_q != 8'h01) ##1 cmd == 3'h1 |=> cmd == 3'h1;
  endproperty
  a_triple: assert property (p_triple)
    else $error("mode set run too short");
  property p_dummy_low; cmd == 3'h1 ##1 cmd == 3'h1 |-> $past(addr) == 0;
  endproperty
  a_dummy_low: assert property (p_dummy_low)
    else $error("dummy set address not low");
  property p_high_zero; cmd == 3'h1 |-> addr[18:10] == 9'h000; endproperty
  a_high_zero: assert property (p_high_zero)
    else $error("upper address bits set");
  property p_recovery;
    cmd != 3'h0 && !(cmd == 3'h1 && gap_q == 8'h01)
      |-> gap_q >= RECOVERY_CYCLES;
  endproperty
  a_recovery: assert property (p_recovery)
    else $error("recovery time short");
  property p_ref_bank; cmd == 3'h2 |-> bank == ref_q[2:0] && ref_q < 4'h8;
  endproperty
  a_ref_bank: assert property (p_ref_bank)
    else $error("refresh bank out of order");
  property p_ref_gap; cmd == 3'h2 |=> cmd != 3'h2 [*8]; endproperty
  a_ref_gap: assert property (p_ref_gap)
    else $error("refreshes too close");
  property p_no_rsv;
    cmd == 3'h1 |-> addr[2:0] < 3'h6 && addr[4:3] != 2'h3;
  endproperty
  a_no_rsv: assert property (p_no_rsv)
    else $error("reserved code programmed");
  c_triple: cover property (cmd == 3'h1 [*3]);
  c_last_ref: cover property (cmd == 3'h2 && bank == 3'h7);
  c_mux_set: cover property (cmd == 3'h1 && addr[5]);
endmodule

/* File: tb/dram_init_and_mode_set_tb_top.sv */
// self-checking bench for the init and mode set link
`timescale 1ns/1ps
module dram_init_and_mode_set_tb_top;
  logic        clk, nrst, mode_req, dll_relock_req, banks_idle;
  logic        ready, read_allowed, busy, on_die_termination_enable, imp, dll, amux, ill;
  logic [17:0] mode_value;
  logic [1:0]  blf;
  logic [3:0]  beats, rc, rl, wl;
  int          errors, n_compared, i, n;
  // mode, flags {odt,imp,dll,amux}, beats, row/read/write, illegal
  logic [38:0] rows [9] = '{
    {18'h00002, 8'h02, 12'h667, 1'b0}, {18'h0000B, 8'h04, 12'h889, 1'b0},
    {18'h00315, 8'hC8, 12'h556, 1'b0}, {18'h00021, 8'h12, 12'h456, 1'b0},
    {18'h00004, 8'h02, 12'h334, 1'b0}, {18'h00006, 8'h02, 12'h889, 1'b0},
    {18'h00019, 8'h04, 12'h445, 1'b0}, {18'h00014, 8'h08, 12'h334, 1'b1},
    {18'h00080, 8'h22, 12'h445, 1'b0}};
  wire  [20:0] obs = {on_die_termination_enable, imp, dll, amux, beats, rc, rl, wl, ill};
  dims_if u_if ();
  dims_ctrl #(.STABLE_CYCLES(20), .RECOVERY_CYCLES(6)) u_dims_ctrl (
    .clk(clk), .nrst(nrst), .pins(u_if.ctrl), .mode_value(mode_value),
    .mode_req(mode_req), .dll_relock_req(dll_relock_req),
    .banks_idle(banks_idle), .ready(ready), .read_allowed(read_allowed),
    .busy(busy));
  dims_mem u_dims_mem (
    .clk(clk), .nrst(nrst), .pins(u_if.mem), .on_die_term(on_die_termination_enable),
    .impedance_source_select(imp), .dll_enable(dll),
    .address_mux_select(amux), .burst_length_field(blf),
    .burst_beats(beats), .row_cycle_cycles(rc), .read_latency_cycles(rl),
    .write_latency_cycles(wl), .mode_illegal(ill));
  dims_checker #(.STABLE_CYCLES(20), .RECOVERY_CYCLES(6)) u_dims_checker (
    .clk(clk), .nrst(nrst), .cmd(u_if.cmd), .addr(u_if.addr),
    .bank(u_if.bank));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic end_sim;
    if (errors == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk_mode(input logic [20:0] got, input logic [20:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_flag(input logic got, input logic exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // bounded wait; a hang ends the run through the verdict
  task automatic wait_lvl(input logic lvl);
    for (int k = 0; k < 3000 && ready !== lvl; k++) @(negedge clk);
    chk_flag(ready, lvl);
    if (ready !== lvl) end_sim();
  endtask
  task automatic req(input logic [17:0] m, input logic relock);
    mode_value = m;
    mode_req = !relock;
    dll_relock_req = relock;
    wait_lvl(1'b0);
    mode_req = 1'b0;
    dll_relock_req = 1'b0;
    wait_lvl(1'b1);
  endtask
  // lock count starts at the set, a few cycles before ready
  task automatic chk_lock;
    int k;
    k = 0;
    chk_flag(read_allowed, 1'b0);
    while (read_allowed !== 1'b1 && k < 2000) begin
      @(negedge clk);
      k++;
    end
    chk_flag(k >= 1010 && k < 2000, 1'b1);
  endtask
  initial begin
    nrst = 1'b0;
    mode_req = 1'b0;
    dll_relock_req = 1'b0;
    banks_idle = 1'b1;
    mode_value = 18'h00000;
    errors = 0;
    n_compared = 0;
    repeat (12) @(negedge clk);
    nrst = 1'b1;
    n = 0;
    while (ready !== 1'b1 && n < 3000) begin
      @(negedge clk);
      n++;
    end
    chk_flag(n >= 1047 && n < 3000, 1'b1);
    chk_mode(obs, {8'h02, 12'h445, 1'b0});
    chk_flag(busy, 1'b0);
    for (i = 0; i < 9; i++) begin
      req(rows[i][38:21], 1'b0);
      chk_mode(obs, rows[i][20:0]);
      chk_mode({19'h0, blf}, {19'h0, 2'(rows[i][16:13] >> 2)});
    end
    chk_lock();
    req(18'h00080, 1'b1);
    chk_lock();
    chk_mode(obs, rows[8][20:0]);
    banks_idle = 1'b0;
    mode_value = 18'h00002;
    mode_req = 1'b1;
    repeat (30) @(negedge clk);
    chk_flag(ready, 1'b1);
    mode_req = 1'b0;
    banks_idle = 1'b1;
    chk_mode(obs, rows[8][20:0]);
    nrst = 1'b0;
    repeat (12) @(negedge clk);
    chk_flag(ready, 1'b0);
    chk_mode(obs, {8'h02, 12'h445, 1'b0});
    nrst = 1'b1;
    wait_lvl(1'b1);
    end_sim();
  end
endmodule
